// ===== uec_map.svh
`ifndef UEC_MAP_SVH
`define UEC_MAP_SVH

// register byte offsets on the bus
`define UEC_EP_CTRL_BASE 12'h000
`define UEC_DEV_ADDR 12'h040
`define UEC_FRAME_LOW 12'h044
`define UEC_FRAME_HIGH 12'h048
`define UEC_CONTROL 12'h04C
`define UEC_STATUS 12'h050
`define UEC_RAM_WINDOW 16'h1000

// endpoint control fields
`define UEC_EP_HANDSHAKE 4
`define UEC_EP_CTRL_DIS 3
`define UEC_EP_OUT_EN 2
`define UEC_EP_IN_EN 1
`define UEC_EP_STALL 0
`define UEC_EP_RESET 8'h00
`define UEC_EP_WMASK 8'h1F

// control and status fields
`define UEC_CTL_ACTIVE 0
`define UEC_CTL_SUSPEND 1
`define UEC_STS_BUS_RESET 0
`define UEC_STS_FRAME_OK 1

// dual-access memory and descriptor table
`define UEC_RAM_LAST 12'hEBF
`define UEC_DESC_BASE 12'hD00
`define UEC_DESC_LAST 12'hDFF
`define UEC_DESC_OWNER 7
`define UEC_DESC_BUFFER_STALL_EN 2

// engine clock rate in MHz; frame capture relies on it running
`define UEC_ENGINE_CLK_MHZ 48

`endif

// ===== uec_pkg.sv
package uec_pkg;

  typedef enum logic [1:0] {
    UEC_TOK_OUT,
    UEC_TOK_IN,
    UEC_TOK_SETUP,
    UEC_TOK_SOF
  } uec_token_kind_t;

  typedef enum logic [1:0] {
    UEC_ANS_NONE,
    UEC_ANS_ACK,
    UEC_ANS_NAK,
    UEC_ANS_STALL
  } uec_answer_t;

  // token decoded by the serial engine
  typedef struct packed {
    uec_token_kind_t kind;
    logic [6:0] addr;
    logic [3:0] endp;
    logic [10:0] frame;
  } uec_token_t;

  // verdict handed back to the serial engine
  typedef struct packed {
    uec_answer_t answer;
    logic handshake;
    logic desc_valid;
    logic [3:0] endp;
    logic [11:0] desc_addr;
  } uec_verdict_t;

endpackage

// ===== uec_endpoint_ctrl.sv
`timescale 1ns/1ns
`include "uec_map.svh"

// Contract
// RQ1: sixteen identical endpoint control registers
// RQ2: handshake enable bit four gates handshakes
// RQ3: cleared control disable admits SETUP tokens
// RQ4: firmware keeps endpoint zero control enabled
// RQ5: OUT accepted only with OUT enable
// RQ6: IN accepted only with IN enable
// RQ7: stall indicator sticky until firmware clears
// RQ8: device address zeroed on reset events
// RQ9: respond to tokens matching device address
// RQ10: firmware writes assigned address
// RQ11: eleven bit frame number in two registers
// RQ12: frame captured on SOF, read only
// RQ13: frame valid only while not suspended
// RQ14: dual-access RAM spans 000h to EBFh
// RQ15: descriptor table occupies D00h to DFFh
// RQ16: firmware respects engine-owned RAM regions
// RQ17: descriptors are four-byte blocks, 64 max
// RQ18: descriptor status at base plus four n
// RQ19: table between 8 and 256 bytes
// RQ20: descriptors live only with IN enable
// RQ21: descriptor memory never initialised by hardware
// RQ22: firmware sets descriptors before enabling endpoint
// RQ23: descriptor stall sets indicator and event
// RQ24: owner flag arbitrates descriptor ownership
module uec_endpoint_ctrl #(
  parameter int NUM_EP = 16,
  parameter int RAM_BYTES = 3776
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic tok_valid,
  input wire uec_pkg::uec_token_t tok,
  input wire logic bus_reset,
  output logic verdict_valid,
  output uec_pkg::uec_verdict_t verdict,
  output logic stall_event,
  input wire logic eng_mem_we,
  input wire logic [11:0] eng_mem_addr,
  input wire logic [7:0] eng_mem_wdata,
  output logic [7:0] eng_mem_rdata
);
  import uec_pkg::*;

  localparam int RAM_WORDS = RAM_BYTES / 4;

  // register map on the bus, all word aligned:
  //   endpoint controls from the low end, four bytes apart
  //   device address, frame pair, control and status after them
  //   shared byte memory mirrored into the upper window
  // only haddr bits 15:0 are decoded, so the block aliases
  // every 64 KB; a system decoder must keep hsel narrow

  // architectural state; the memory array has no reset

  logic [7:0] ep_ctrl [NUM_EP];
  logic [6:0] device_address_reg;
  logic [7:0] frame_num_low;
  logic [2:0] frame_num_high;
  logic active;
  logic suspend_bit;
  logic bus_reset_flag;
  logic [7:0] usb_ram [RAM_BYTES];

  // data phase bookkeeping; the address phase is registered so
  // that the write data lines up with the captured address
  logic dp_valid;
  logic dp_write;
  logic [15:0] dp_addr;
  logic [NUM_EP-1:0] stall_set;
  logic [NUM_EP-1:0] ep_wr;
  logic [NUM_EP-1:0] stall_clr;
  logic ram_wr;
  logic [11:0] ram_byte;

  // token decode terms, all combinational from the current token;
  // only the verdict itself is registered
  logic tok_match;
  logic [7:0] tok_ep;
  logic [11:0] tok_desc;
  logic [7:0] tok_stat;
  logic tok_accept;
  logic next_desc_valid;
  uec_answer_t next_answer;

  // descriptor lookup helpers; both are used by the decode and
  // keep the table arithmetic in one place
  // descriptor n sits at the table base plus four bytes per number
  function automatic logic [11:0] desc_addr_of(input logic [5:0] n);
    desc_addr_of = `UEC_DESC_BASE + {4'h0, n, 2'b00};
  endfunction

  // ping-pong banks are not modelled, so only the first 32
  // descriptors are ever looked up
  // descriptor number from endpoint and direction, no ping-pong
  function automatic logic [5:0] desc_num(input logic [3:0] ep,
                                          input logic dir_in);
    desc_num = {1'b0, ep, dir_in};
  endfunction

  // no wait states are ever needed: every register and the memory
  // answer within the data phase, so ready is a constant
  // zero wait states; every answer is OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // hsize is not checked; narrow accesses are treated as words,
  // which firmware must avoid on the memory window
  // address phase capture, only taken while the bus is ready
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_valid <= 1'b0;
      dp_write <= 1'b0;
      dp_addr <= 16'h0000;
    end else if (hready) begin
      // idle and busy transfers leave no data phase behind
      dp_valid <= hsel && htrans[1];
      dp_write <= hwrite;
      dp_addr <= haddr[15:0];
    end
  end

  // the write data is taken straight from hwdata in the data
  // phase, so no data register is needed on the write path
  // write strobes for the data phase, word accesses only
  always_comb begin
    ram_byte = dp_addr[11:0];
    ram_wr = dp_valid && dp_write && dp_addr[15:12] == 4'h1 &&
             dp_addr[11:0] <= `UEC_RAM_LAST;
    for (int i = 0; i < NUM_EP; i++) begin
      ep_wr[i] = dp_valid && dp_write &&
                 dp_addr == {4'h0, `UEC_EP_CTRL_BASE} + 16'(i * 4);
      stall_clr[i] = ep_wr[i] && !hwdata[`UEC_EP_STALL];
    end
  end

  // hrdata is combinational on purpose: a registered read would
  // need a wait state, and the bus master expects none
  // read mux; registers sit in the low bits, the rest reads zero
  always_comb begin
    hrdata = 32'h0000_0000;
    if (dp_valid && !dp_write) begin
      if (dp_addr[15:12] == 4'h1) begin
        if (dp_addr[11:0] <= `UEC_RAM_LAST) begin
          hrdata = {usb_ram[{ram_byte[11:2], 2'b11}],
                    usb_ram[{ram_byte[11:2], 2'b10}],
                    usb_ram[{ram_byte[11:2], 2'b01}],
                    usb_ram[{ram_byte[11:2], 2'b00}]};
        end
      end else if (dp_addr[15:12] == 4'h0) begin
        unique case (dp_addr[11:0])
          `UEC_DEV_ADDR: hrdata = {25'h0, device_address_reg};
          `UEC_FRAME_LOW: hrdata = {24'h0, frame_num_low};
          `UEC_FRAME_HIGH: hrdata = {29'h0, frame_num_high};
          `UEC_CONTROL: hrdata = {30'h0, suspend_bit, active};
          `UEC_STATUS: hrdata = {30'h0, !suspend_bit, bus_reset_flag};
          default: begin
            for (int i = 0; i < NUM_EP; i++) begin
              if (dp_addr[11:0] == `UEC_EP_CTRL_BASE + 12'(i * 4)) begin
                hrdata = {24'h0, ep_ctrl[i]};
              end
            end
          end
        endcase
      end
    end
  end

  // bits 7:5 are not stored and read as zero; firmware writes to
  // bit 0 only clear the stall indicator, never set it
  // one control register per endpoint, laid out the same way
  // RQ1: per-endpoint registers
  generate
    for (genvar g = 0; g < NUM_EP; g++) begin : g_ep
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          ep_ctrl[g] <= `UEC_EP_RESET;
        end else begin
          // firmware write of the enable and control bits
          if (ep_wr[g]) begin
            ep_ctrl[g][4:1] <= hwdata[4:1];
          end
          // RQ7: stall set wins
          if (stall_set[g]) begin
            ep_ctrl[g][`UEC_EP_STALL] <= 1'b1;
          end else if (stall_clr[g]) begin
            ep_ctrl[g][`UEC_EP_STALL] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // the address is seven bits wide, matching the token field;
  // a bus reset drops the device back to the default address
  // device address; bus reset beats a firmware write in the same cycle
  // RQ8: forced to zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      device_address_reg <= 7'h00;
    end else if (bus_reset) begin
      device_address_reg <= 7'h00;
    end else if (dp_valid && dp_write && dp_addr == {4'h0, `UEC_DEV_ADDR}) begin
      device_address_reg <= hwdata[6:0];
    end
  end

  // the active bit gates all token decode; the suspend bit freezes
  // frame capture and clears the frame-ok status bit, tokens are still judged while set
  // control bits and the sticky bus reset flag, write one to clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      active <= 1'b0;
      suspend_bit <= 1'b0;
      bus_reset_flag <= 1'b0;
    end else begin
      if (dp_valid && dp_write && dp_addr == {4'h0, `UEC_CONTROL}) begin
        active <= hwdata[`UEC_CTL_ACTIVE];
        suspend_bit <= hwdata[`UEC_CTL_SUSPEND];
      end
      // hardware set of the flag wins over a clear in one cycle
      if (bus_reset) begin
        bus_reset_flag <= 1'b1;
      end else if (dp_valid && dp_write && dp_addr == {4'h0, `UEC_STATUS} &&
                   hwdata[`UEC_STS_BUS_RESET]) begin
        bus_reset_flag <= 1'b0;
      end
    end
  end

  // a read of the two halves is not atomic: a frame start between
  // the low and high reads can tear the value
  // frame number, loaded on SOF and never written by the cpu;
  // capture is skipped while suspended since the engine clock stops
  // RQ11: split frame number
  // RQ12: captured on SOF
  // RQ13: frozen in suspend
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      frame_num_low <= 8'h00;
      frame_num_high <= 3'h0;
    end else if (tok_valid && tok.kind == UEC_TOK_SOF && active &&
                 !suspend_bit) begin
      frame_num_low <= tok.frame[7:0];
      frame_num_high <= tok.frame[10:8];
    end
  end

  // one byte array serves both ports; the bus side always writes a
  // whole word, the engine side one byte at a time
  // there is no lock against the cpu touching an engine-owned
  // buffer; the owner flag is a software convention only
  // dual-access memory, no reset so descriptors start undefined;
  // the engine wins a byte both sides write in the same cycle
  // RQ14: shared RAM
  // RQ21: no initialisation
  always_ff @(posedge hclk) begin
    if (ram_wr) begin
      for (int b = 0; b < 4; b++) begin
        usb_ram[{ram_byte[11:2], 2'(b)}] <= hwdata[b*8 +: 8];
      end
    end
    if (eng_mem_we && eng_mem_addr <= `UEC_RAM_LAST) begin
      usb_ram[eng_mem_addr] <= eng_mem_wdata;
    end
  end

  // out-of-range engine reads return zero rather than aliasing
  // into the memory
  // engine read port, registered
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      eng_mem_rdata <= 8'h00;
    end else if (eng_mem_addr <= `UEC_RAM_LAST) begin
      eng_mem_rdata <= usb_ram[eng_mem_addr];
    end else begin
      eng_mem_rdata <= 8'h00;
    end
  end

  // decision order: address and active, direction enables, then
  // descriptor owner and buffer stall; a cpu-owned descriptor is
  // answered with NAK so the host retries later
  // the descriptor read is combinational from the array, which
  // keeps the verdict at one cycle after the token
  // token decode: address match, endpoint enables, descriptor lookup
  // RQ9: address match
  // RQ17: four-byte blocks
  // RQ18: base plus four n
  // RQ15: table in bank 13
  always_comb begin
    tok_match = active && tok.addr == device_address_reg &&
                tok.kind != UEC_TOK_SOF;
    tok_ep = ep_ctrl[tok.endp];
    tok_desc = desc_addr_of(desc_num(tok.endp, tok.kind == UEC_TOK_IN));
    tok_stat = usb_ram[tok_desc];
    // RQ20: descriptor live with IN enable
    // RQ19: endpoint zero needs 8 bytes
    next_desc_valid = tok_ep[`UEC_EP_IN_EN] && tok_desc <= `UEC_DESC_LAST;
    // default refusal, overridden per token kind below
    tok_accept = 1'b0;
    unique case (tok.kind)
      // RQ5: OUT enable
      UEC_TOK_OUT: tok_accept = tok_ep[`UEC_EP_OUT_EN];
      // RQ6: IN enable
      UEC_TOK_IN: tok_accept = tok_ep[`UEC_EP_IN_EN];
      // RQ3: SETUP admission
      UEC_TOK_SETUP: tok_accept = tok_ep[`UEC_EP_OUT_EN] &&
                                  tok_ep[`UEC_EP_IN_EN] &&
                                  !tok_ep[`UEC_EP_CTRL_DIS];
      UEC_TOK_SOF: tok_accept = 1'b0;
    endcase
    // no answer unless the token is both for us and admitted
    next_answer = UEC_ANS_NONE;
    if (tok_match && tok_accept) begin
      // RQ24: cpu-owned descriptor is not used
      if (!next_desc_valid || !tok_stat[`UEC_DESC_OWNER]) begin
        next_answer = UEC_ANS_NAK;
      // RQ23: buffer stall
      end else if (tok_stat[`UEC_DESC_BUFFER_STALL_EN] &&
                   tok.kind != UEC_TOK_SETUP) begin
        next_answer = UEC_ANS_STALL;
      end else begin
        next_answer = UEC_ANS_ACK;
      end
    end
  end

  // the stall indicator is set from the registered verdict, so it
  // becomes visible one cycle after the stall answer
  // a stall counts as sent once the verdict goes out
  always_comb begin
    for (int i = 0; i < NUM_EP; i++) begin
      stall_set[i] = verdict_valid && verdict.answer == UEC_ANS_STALL &&
                     verdict.endp == 4'(i);
    end
  end

  // verdict fields hold until the next token, so the engine may
  // read them late; valid and the stall event are single pulses
  // verdict register, one cycle after the token
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      verdict_valid <= 1'b0;
      verdict <= '0;
      stall_event <= 1'b0;
    end else begin
      // refused tokens store a NONE answer but raise no valid
      verdict_valid <= tok_valid && next_answer != UEC_ANS_NONE;
      stall_event <= tok_valid && next_answer == UEC_ANS_STALL;
      if (tok_valid) begin
        verdict.answer <= next_answer;
        // RQ2: handshake enable
        verdict.handshake <= tok_ep[`UEC_EP_HANDSHAKE] &&
                             next_answer != UEC_ANS_NONE;
        verdict.desc_valid <= next_desc_valid;
        verdict.endp <= tok.endp;
        verdict.desc_addr <= tok_desc;
      end
    end
  end

endmodule

// ===== uec_ep_checker.sv
`timescale 1ns/1ns
// watches the block ports; answers tied back to their token
module uec_ep_checker #(
  parameter int NUM_EP = 16,
  parameter int RAM_BYTES = 3776
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic tok_valid,
  input wire uec_pkg::uec_token_t tok,
  input wire logic verdict_valid,
  input wire uec_pkg::uec_verdict_t verdict,
  input wire logic stall_event,
  input wire logic [11:0] eng_mem_addr,
  input wire logic [7:0] eng_mem_rdata
);
  import uec_pkg::*;
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  a_bus_zero_wait: assert property (
    hreadyout && !hresp) else $error("slave stalled or errored");
  a_sof_silent: assert property (
    tok_valid && tok.kind == UEC_TOK_SOF |=> !verdict_valid)
    else $error("frame start answered");
  a_verdict_cause: assert property (
    verdict_valid |-> $past(tok_valid) && verdict.endp == $past(tok.endp))
    else $error("answer without matching token");
  a_stall_pulse: assert property (
    stall_event == (verdict_valid && verdict.answer == UEC_ANS_STALL))
    else $error("stall event and stall answer disagree");
  a_hshk_answer: assert property (
    verdict.handshake |-> verdict.answer != UEC_ANS_NONE)
    else $error("handshake with no answer");
  // descriptor n status at base plus four n, n = 2 endp + in
  a_desc_slot: assert property (
    verdict_valid |-> verdict.desc_addr == {5'h1A, $past(tok.endp),
    $past(tok.kind) == UEC_TOK_IN, 2'h0})
    else $error("descriptor address wrong");
  a_setup_stall: assert property (
    tok_valid && tok.kind == UEC_TOK_SETUP |=>
    verdict.answer != UEC_ANS_STALL) else $error("setup stalled");
  a_ram_bound: assert property (
    eng_mem_addr >= 12'(RAM_BYTES) |=> eng_mem_rdata == 8'h00)
    else $error("engine read past memory end");

  a_ack_desc: assert property (
    verdict_valid && verdict.answer == UEC_ANS_ACK |-> verdict.desc_valid)
    else $error("ack without live descriptor");

  c_stall: cover property (stall_event);
  c_nak: cover property (verdict_valid && verdict.answer == UEC_ANS_NAK);
  c_sof: cover property (tok_valid && tok.kind == UEC_TOK_SOF);
endmodule

bind uec_endpoint_ctrl uec_ep_checker #(.NUM_EP(NUM_EP),
  .RAM_BYTES(RAM_BYTES)) chk_u (.hclk, .hresetn, .hreadyout, .hresp,
  .tok_valid, .tok, .verdict_valid, .verdict, .stall_event,
  .eng_mem_addr, .eng_mem_rdata);

// ===== uec_host_model.sv
`timescale 1ns/1ns
// token source in place of the bus-side decoder
module uec_host_model (
  input wire logic hclk,
  output logic tok_valid,
  output uec_pkg::uec_token_t tok,
  output logic bus_reset
);
  import uec_pkg::*;
  // quiet lines at time zero
  initial begin
    tok_valid = 1'b0;
    tok = '0;
    bus_reset = 1'b0;
  end
  // idle token lines show the inverse, so stale values never pass
  task automatic send(input uec_token_kind_t k, input logic [6:0] a,
    input logic [3:0] e, input logic [10:0] f);
    tok_valid <= 1'b1;
    tok <= '{kind: k, addr: a, endp: e, frame: f};
    @(posedge hclk);
    tok_valid <= 1'b0;
    tok <= ~tok;
  endtask
  // one-cycle bus reset pulse
  task automatic breset;
    bus_reset <= 1'b1;
    @(posedge hclk);
    bus_reset <= 1'b0;
  endtask
endmodule

// ===== usb_endpoint_ctrl_bdt_tb.sv
`timescale 1ns/1ns
`include "uec_map.svh"
module usb_endpoint_ctrl_bdt_tb;
  import uec_pkg::*;
  logic hclk, hready, hreadyout, hresp, tok_valid, bus_reset;
  logic hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, eng_mem_we = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic verdict_valid, stall_event;
  uec_token_t tok;
  uec_verdict_t verdict;
  logic [11:0] eng_mem_addr = 12'h000;
  logic [7:0] eng_mem_wdata = 8'h00, eng_mem_rdata;
  int err_count = 0;
  int compares = 0;

  assign hready = hreadyout;
  uec_endpoint_ctrl dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .tok_valid, .tok,
    .bus_reset, .verdict_valid, .verdict, .stall_event, .eng_mem_we,
    .eng_mem_addr, .eng_mem_wdata, .eng_mem_rdata);
  uec_host_model host_u (.hclk, .tok_valid, .tok, .bus_reset);

  // 125 MHz clock
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end

  task automatic complete_run;
    $display("mismatches %0d, compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // bounded wait for ready at a rising edge
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 64);
    if (hready !== 1'b1) begin
      err_count++;
      complete_run;
    end
  endtask

  task automatic bus(input logic w, input logic [15:0] a,
    input logic [31:0] d);
    hsel <= 1'b1;
    hwrite <= w;
    haddr <= {16'h0000, a};
    htrans <= 2'h2;
    wait_rdy;
    htrans <= 2'h0;
    hwdata <= w ? d : ~hwdata;
    wait_rdy;
  endtask

  task automatic rd(input logic [15:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(hrdata, exp);
  endtask

  // exp = {stall_event, verdict_valid, answer, handshake}
  task automatic tk(input uec_token_kind_t k, input logic [6:0] a,
    input logic [3:0] e, input logic [7:0] exp);
    host_u.send(k, a, e, 11'h000);
    @(negedge hclk);
    chk(32'({stall_event, verdict_valid, verdict}) >> 17, 32'(exp));
    @(posedge hclk);
  endtask

  // engine byte port; read data lands one edge after the address
  task automatic eng(input logic w, input logic [11:0] a,
    input logic [7:0] d);
    eng_mem_we <= w;
    eng_mem_addr <= a;
    eng_mem_wdata <= d;
    @(posedge hclk);
    eng_mem_we <= 1'b0;
    @(negedge hclk);
    if (!w) chk(32'(eng_mem_rdata), 32'(d));
    @(posedge hclk);
  endtask

  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 0; i < 16; i++) begin
      rd(16'(4 * i), 32'h0);
      bus(1'b1, 16'(4 * i), 32'hE0 | 32'(2 * i));
    end
    for (int i = 0; i < 16; i++) rd(16'(4 * i), 32'(2 * i));
    bus(1'b1, 16'h0800, 32'hFFFFFFFF);
    rd(16'h0800, 32'h0);
    rd(`UEC_DEV_ADDR, 32'h0);
    bus(1'b1, `UEC_CONTROL, 32'h1);
    bus(1'b1, `UEC_DEV_ADDR, 32'h5);
    bus(1'b1, 16'h1D00, 32'h80);
    bus(1'b1, 16'h1D04, 32'h0);
    bus(1'b1, 16'h1D08, 32'h80);
    bus(1'b1, 16'h1D0C, 32'h84);
    bus(1'b1, 16'h1D18, 32'h80);
    bus(1'b1, 16'h0000, 32'h16);
    bus(1'b1, 16'h0004, 32'h0E);
    bus(1'b1, 16'h0008, 32'h0);
    bus(1'b1, 16'h000C, 32'h4);
    tk(UEC_TOK_OUT, 7'h05, 4'h0, 8'h0B);
    tk(UEC_TOK_IN, 7'h05, 4'h0, 8'h0D);
    tk(UEC_TOK_SETUP, 7'h05, 4'h0, 8'h0B);
    tk(UEC_TOK_SETUP, 7'h05, 4'h1, 8'h00);
    tk(UEC_TOK_OUT, 7'h06, 4'h0, 8'h00);
    tk(UEC_TOK_OUT, 7'h05, 4'h2, 8'h00);
    tk(UEC_TOK_IN, 7'h05, 4'h2, 8'h00);
    tk(UEC_TOK_OUT, 7'h05, 4'h1, 8'h0A);
    tk(UEC_TOK_OUT, 7'h05, 4'h3, 8'h0C);
    tk(UEC_TOK_IN, 7'h05, 4'h1, 8'h1E);
    rd(16'h0004, 32'h0F);
    bus(1'b1, 16'h0004, 32'h0F);
    rd(16'h0004, 32'h0F);
    bus(1'b1, 16'h0004, 32'h0E);
    rd(16'h0004, 32'h0E);
    host_u.send(UEC_TOK_SOF, 7'h05, 4'h0, 11'h5A3);
    bus(1'b1, `UEC_FRAME_LOW, 32'hFF);
    rd(`UEC_FRAME_LOW, 32'hA3);
    rd(`UEC_FRAME_HIGH, 32'h5);
    bus(1'b1, `UEC_CONTROL, 32'h3);
    rd(`UEC_STATUS, 32'h0);
    host_u.send(UEC_TOK_SOF, 7'h05, 4'h0, 11'h123);
    rd(`UEC_FRAME_LOW, 32'hA3);
    bus(1'b1, `UEC_CONTROL, 32'h1);
    host_u.breset;
    rd(`UEC_DEV_ADDR, 32'h0);
    rd(`UEC_STATUS, 32'h3);
    bus(1'b1, `UEC_STATUS, 32'h1);
    rd(`UEC_STATUS, 32'h2);
    tk(UEC_TOK_OUT, 7'h05, 4'h0, 8'h00);
    tk(UEC_TOK_OUT, 7'h00, 4'h0, 8'h0B);
    bus(1'b1, 16'h1500, 32'h11223344);
    eng(1'b1, 12'h501, 8'hA5);
    rd(16'h1500, 32'h1122A544);
    bus(1'b1, 16'h1EBC, 32'hAB000000);
    eng(1'b0, 12'hEBF, 8'hAB);
    eng(1'b0, 12'hD0C, 8'h84);
    eng(1'b0, 12'hEC0, 8'h00);
    // second reset in mid-run clears the endpoint 1 enables; address stays zero
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(16'h0004, 32'h0);
    rd(`UEC_DEV_ADDR, 32'h0);
    complete_run;
  end
endmodule
